/* src/mfs_regs.vh */
// Purpose: Register map and field constants for the frame statistics block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes:   Counters clear on read and saturate at all ones
`ifndef MFS_REGS_VH
`define MFS_REGS_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define MFS_OFS_CTRL      8'h00
`define MFS_OFS_TX_GOOD   8'h04
`define MFS_OFS_TX_ONE    8'h08
`define MFS_OFS_TX_SEV    8'h0C
`define MFS_OFS_RX_GOOD   8'h10
`define MFS_OFS_RX_CRC    8'h14
`define MFS_OFS_RX_PART   8'h18
`define MFS_OFS_TX_DEF    8'h1C
`define MFS_OFS_TX_LATE   8'h20
`define MFS_OFS_TX_RETRY  8'h24
`define MFS_OFS_TX_STARV  8'h28
`define MFS_OFS_TX_CARR   8'h2C
`define MFS_OFS_RX_NOBUF  8'h30
// ------------------------------------------------------------
// Control fields and values
// ------------------------------------------------------------
`define MFS_CTRL_RX_EN    3
`define MFS_CTRL_WR_EN    7
`define MFS_CTRL_LONG     8
`define MFS_CTRL_HALF     9
`define MFS_CTRL_MASK     32'h0000_0388
`define MFS_CTRL_RESET    32'h0000_0000
`define MFS_LEN_MIN       11'h040
`define MFS_LEN_MAX       11'h5EE
`define MFS_LEN_MAX_LONG  11'h600
`define MFS_COL_RETRY     5'h10
`endif

/* src/mfs_stats.v */
// Purpose: Ethernet MAC frame statistics counters behind Wishbone
// Assumes: Frame engines pulse a done strobe with the outcome, one clock
// Notes:   Ack comes one cycle after the request; reads clear counters
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "mfs_regs.vh"
module mfs_stats
#(
  parameter LEN_W = 11
)
(
  input  wire             clk_i,
  input  wire             rst_i,
  // Register bus
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [7:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  // Transmit frame engine report
  input  wire             tx_done_i,
  input  wire             tx_underrun_i,
  input  wire [4:0]       tx_collisions_i,
  input  wire             tx_late_col_i,
  input  wire             tx_deferred_i,
  input  wire             tx_carrier_lost_i,
  // Receive frame engine report
  input  wire             rx_done_i,
  input  wire             rx_addr_match_i,
  input  wire             rx_stored_i,
  input  wire             rx_no_buffer_i,
  input  wire [LEN_W-1:0] rx_length_i,
  input  wire             rx_partial_byte_i,
  input  wire             rx_crc_bad_i,
  input  wire             rx_symbol_err_i,
  // Control bits mirrored to the MAC
  output reg              rx_enable_o,
  output reg              half_duplex_o
);
  // ------------------------------------------------------------
  // Counter helper
  // ------------------------------------------------------------
  // All-ones value of a counter of width w, its saturation point
  function [23:0] cnt_top;
    input [4:0] w;
    begin
      cnt_top = (24'h000001 << w) - 24'h000001;
    end
  endfunction

  // Clear, load or count one, saturating at the width's all ones
  function [23:0] nxt;
    input [23:0] cur;
    input [4:0]  w;
    input        inc;
    input        clr;
    input        ld;
    input [23:0] val;
    reg   [23:0] top;
    reg   [23:0] base;
    begin
      top  = cnt_top(w);
      base = ld ? (val & top) : (clr ? 24'h000000 : cur);
      if (inc && (clr || (base != top)))
        nxt = (clr && !ld) ? 24'h000001 : base + 24'h000001;
      else
        nxt = base;
    end
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire        req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        rd     = req & ~wb_we_i;
  wire        wr     = req & wb_we_i & (wb_sel_i == 4'hF);
  reg  [31:0] ctrl_q;
  wire        wr_en  = ctrl_q[`MFS_CTRL_WR_EN];
  wire        rx_en  = ctrl_q[`MFS_CTRL_RX_EN];
  wire        half   = ctrl_q[`MFS_CTRL_HALF];
  wire [23:0] wval   = wb_dat_i[23:0];
  // Indexed counters; slot 0 unused so index equals offset / 4
  reg  [23:0] cnt_q [1:12];
  reg  [12:1] clr_hit;
  reg  [12:1] ld_hit;
  reg  [12:1] inc;
  wire [3:0]  idx    = wb_adr_i[5:2];
  wire        in_map = (wb_adr_i[7:6] == 2'b00) && (wb_adr_i[1:0] == 2'b00)
                       && (wb_adr_i <= `MFS_OFS_RX_NOBUF);

  // ------------------------------------------------------------
  // Frame classification
  // ------------------------------------------------------------
  wire [LEN_W-1:0] lmax = ctrl_q[`MFS_CTRL_LONG] ? `MFS_LEN_MAX_LONG
                                                 : `MFS_LEN_MAX;
  wire len_ok = (rx_length_i >= `MFS_LEN_MIN) && (rx_length_i <= lmax);
  wire tx_ok  = ~tx_underrun_i & (tx_collisions_i < `MFS_COL_RETRY);
  wire rx_act = rx_done_i & rx_en;
  wire rx_bad = rx_crc_bad_i | rx_symbol_err_i;

  // Transmit outcome; an underrun frame feeds only its own counter
  wire tx_fin      = tx_done_i & ~tx_underrun_i;
  wire tx_no_col   = (tx_collisions_i == 5'h00);
  wire ev_tx_good  = tx_fin & tx_ok;
  wire ev_tx_one   = tx_fin & (tx_collisions_i == 5'h01);
  wire ev_tx_sev   = tx_fin & tx_ok & (tx_collisions_i >= 5'h02);
  wire ev_tx_def   = tx_fin & tx_deferred_i & tx_no_col;
  wire ev_tx_late  = tx_fin & tx_late_col_i;
  wire ev_tx_retry = tx_fin & ~tx_ok;
  wire ev_tx_starv = tx_done_i & tx_underrun_i;
  // Carrier loss counts only in half duplex with no collisions and never masks another event
  wire ev_tx_carr  = tx_fin & tx_carrier_lost_i
                     & half & tx_no_col;

  // Receive outcome, gated by the receive enable
  wire rx_hit      = rx_act & rx_addr_match_i;
  wire ev_rx_good  = rx_hit & rx_stored_i & len_ok & ~rx_bad
                     & ~rx_partial_byte_i;
  wire rx_err_ok   = rx_act & len_ok & rx_bad;
  wire ev_rx_crc   = rx_err_ok & ~rx_partial_byte_i;
  wire ev_rx_part  = rx_err_ok & rx_partial_byte_i;
  wire ev_rx_nobuf = rx_hit & rx_no_buffer_i;

  // One update per frame end collects every counter's event
  always @*
  begin
    inc[1]  = ev_tx_good;
    inc[2]  = ev_tx_one;
    inc[3]  = ev_tx_sev;
    inc[4]  = ev_rx_good;
    inc[5]  = ev_rx_crc;
    inc[6]  = ev_rx_part;
    inc[7]  = ev_tx_def;
    inc[8]  = ev_tx_late;
    inc[9]  = ev_tx_retry;
    inc[10] = ev_tx_starv;
    inc[11] = ev_tx_carr;
    inc[12] = ev_rx_nobuf;
  end

  // ------------------------------------------------------------
  // Counters
  // ------------------------------------------------------------
  integer j;

  // Width of each counter by index (offset / 4)
  function [4:0] cnt_width;
    input [3:0] n;
    begin
      case (n)
        4'h1:
          cnt_width = 5'h18;
        4'h2:
          cnt_width = 5'h10;
        4'h3:
          cnt_width = 5'h10;
        4'h4:
          cnt_width = 5'h18;
        4'h5:
          cnt_width = 5'h08;
        4'h6:
          cnt_width = 5'h08;
        4'h7:
          cnt_width = 5'h10;
        4'h8:
          cnt_width = 5'h08;
        4'h9:
          cnt_width = 5'h08;
        4'hA:
          cnt_width = 5'h08;
        4'hB:
          cnt_width = 5'h08;
        4'hC:
          cnt_width = 5'h10;
        default:
          cnt_width = 5'h08;
      endcase
    end
  endfunction

  // Bus hits per counter; reading a counter is what clears it
  always @*
  begin
    clr_hit = 12'h000;
    ld_hit  = 12'h000;
    for (j = 1; j <= 12; j = j + 1)
    begin
      if (in_map && (idx == j[3:0]))
      begin
        clr_hit[j] = rd;
        ld_hit[j]  = wr & wr_en;
      end
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q[1]  <= 24'h000000;
      cnt_q[2]  <= 24'h000000;
      cnt_q[3]  <= 24'h000000;
      cnt_q[4]  <= 24'h000000;
      cnt_q[5]  <= 24'h000000;
      cnt_q[6]  <= 24'h000000;
      cnt_q[7]  <= 24'h000000;
      cnt_q[8]  <= 24'h000000;
      cnt_q[9]  <= 24'h000000;
      cnt_q[10] <= 24'h000000;
      cnt_q[11] <= 24'h000000;
      cnt_q[12] <= 24'h000000;
    end
    else
    begin
      cnt_q[1]  <= nxt(cnt_q[1], cnt_width(4'h1), inc[1], clr_hit[1],
                       ld_hit[1], wval);
      cnt_q[2]  <= nxt(cnt_q[2], cnt_width(4'h2), inc[2], clr_hit[2],
                       ld_hit[2], wval);
      cnt_q[3]  <= nxt(cnt_q[3], cnt_width(4'h3), inc[3], clr_hit[3],
                       ld_hit[3], wval);
      cnt_q[4]  <= nxt(cnt_q[4], cnt_width(4'h4), inc[4], clr_hit[4],
                       ld_hit[4], wval);
      cnt_q[5]  <= nxt(cnt_q[5], cnt_width(4'h5), inc[5], clr_hit[5],
                       ld_hit[5], wval);
      cnt_q[6]  <= nxt(cnt_q[6], cnt_width(4'h6), inc[6], clr_hit[6],
                       ld_hit[6], wval);
      cnt_q[7]  <= nxt(cnt_q[7], cnt_width(4'h7), inc[7], clr_hit[7],
                       ld_hit[7], wval);
      cnt_q[8]  <= nxt(cnt_q[8], cnt_width(4'h8), inc[8], clr_hit[8],
                       ld_hit[8], wval);
      cnt_q[9]  <= nxt(cnt_q[9], cnt_width(4'h9), inc[9], clr_hit[9],
                       ld_hit[9], wval);
      cnt_q[10] <= nxt(cnt_q[10], cnt_width(4'hA), inc[10], clr_hit[10],
                       ld_hit[10], wval);
      cnt_q[11] <= nxt(cnt_q[11], cnt_width(4'hB), inc[11], clr_hit[11],
                       ld_hit[11], wval);
      cnt_q[12] <= nxt(cnt_q[12], cnt_width(4'hC), inc[12], clr_hit[12],
                       ld_hit[12], wval);
    end
  end

  // ------------------------------------------------------------
  // Byte lanes
  // ------------------------------------------------------------
  // Only the control register honours partial selects
  function [31:0] lanes;
    input [3:0] s;
    begin
      lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  // ------------------------------------------------------------
  // Control register and bus answer
  // ------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q        <= `MFS_CTRL_RESET;
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h0000_0000;
      rx_enable_o   <= 1'b0;
      half_duplex_o <= 1'b0;
    end
    else
    begin
      wb_ack_o      <= req;
      rx_enable_o   <= rx_en;
      half_duplex_o <= half;
      if (req && wb_we_i && (wb_adr_i == `MFS_OFS_CTRL))
        ctrl_q <= (ctrl_q & ~lanes(wb_sel_i))
                | (wb_dat_i & `MFS_CTRL_MASK & lanes(wb_sel_i));
      if (rd)
      begin
        case (wb_adr_i)
          `MFS_OFS_CTRL:
            wb_dat_o <= ctrl_q;
          `MFS_OFS_TX_GOOD:
            wb_dat_o <= {8'h00, cnt_q[1]};
          `MFS_OFS_TX_ONE:
            wb_dat_o <= {8'h00, cnt_q[2]};
          `MFS_OFS_TX_SEV:
            wb_dat_o <= {8'h00, cnt_q[3]};
          `MFS_OFS_RX_GOOD:
            wb_dat_o <= {8'h00, cnt_q[4]};
          `MFS_OFS_RX_CRC:
            wb_dat_o <= {8'h00, cnt_q[5]};
          `MFS_OFS_RX_PART:
            wb_dat_o <= {8'h00, cnt_q[6]};
          `MFS_OFS_TX_DEF:
            wb_dat_o <= {8'h00, cnt_q[7]};
          `MFS_OFS_TX_LATE:
            wb_dat_o <= {8'h00, cnt_q[8]};
          `MFS_OFS_TX_RETRY:
            wb_dat_o <= {8'h00, cnt_q[9]};
          `MFS_OFS_TX_STARV:
            wb_dat_o <= {8'h00, cnt_q[10]};
          `MFS_OFS_TX_CARR:
            wb_dat_o <= {8'h00, cnt_q[11]};
          `MFS_OFS_RX_NOBUF:
            wb_dat_o <= {8'h00, cnt_q[12]};
          default:
            wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/mfs_stats_properties.sv */
// Purpose: Port checks for the frame statistics block
// Assumes: Single clock, synchronous active-high reset
// Notes:   Ack latency of one cycle as handed over
`timescale 1ns/1ns
`default_nettype none
module mfs_stats_properties
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_ack;
    wb_ack_o && !wb_we_i;
  endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answers: assert property (s_take |=> wb_ack_o)
    else $error("request not answered");
  a_ack_no_req: assert property ((!wb_cyc_i || !wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o
    && wb_dat_o == 32'h0) else $error("bus not idle after reset");
  a_unmapped_zero: assert property (s_rd_ack ##0 wb_adr_i > 8'h30
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_byte_upper_zero: assert property (s_rd_ack ##0 wb_adr_i inside
    {8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2C} |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper bits set on byte counter");
  a_half_upper_zero: assert property (s_rd_ack ##0 wb_adr_i inside
    {8'h08, 8'h0C, 8'h1C, 8'h30} |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper bits set on half counter");
  a_read_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o
    && !wb_we_i) |=> $stable(wb_dat_o)) else $error("read data moved");
endmodule
bind mfs_stats mfs_stats_properties chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

/* testbench/mfs_eng_model.sv */
// Purpose: Stand-in for the transmit and receive frame engines
// Assumes: A request cycle yields a done pulse one edge later
// Notes:   Qualifiers flip outside done so stale values never help
`timescale 1ns/1ns
`default_nettype none
module mfs_eng_model
(
  input  wire logic        clk_i,
  input  wire logic [1:0]  req_i,
  input  wire logic [25:0] vec_i,
  output var  logic [1:0]  done_o,
  output var  logic [25:0] vec_o
);
  initial {done_o, vec_o} = 28'h0;
  always @(posedge clk_i)
  begin
    done_o <= req_i;
    vec_o <= (req_i != 2'b00) ? vec_i : ~vec_o;
  end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Purpose: Self-checking bench for the frame statistics block
// Assumes: Frame engines stood in by mfs_eng_model
// Notes:   Scoreboard mirrors every counter from port activity
`timescale 1ns/1ns
`default_nettype none
`include "mfs_regs.vh"
module tb;
  localparam int lens [6] = '{63, 64, 1518, 1519, 1536, 1537};
  localparam logic [31:0] ctls [4] = '{32'hFFFFFFFF, 32'h00000080,
    32'h00000308, 32'h00000088};
  logic clk = 0, rst = 1, ack, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [1:0] rq = 2'h0, dn;
  logic [25:0] vw = 26'h0, v;
  logic [31:0] dat = 32'h0, dato, rdexp, ctl;
  logic [23:0] cnt [12];
  logic [11:0] inc;
  logic ren, hdx;
  integer seed = 12041, miscompares = 0, compares = 0, i, p;
  always #2 clk = ~clk;
  mfs_stats dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .tx_done_i(dn[0]),
    .tx_underrun_i(v[25]), .tx_collisions_i(v[24:20]),
    .tx_late_col_i(v[19]), .tx_deferred_i(v[18]),
    .tx_carrier_lost_i(v[17]), .rx_done_i(dn[1]), .rx_addr_match_i(v[16]),
    .rx_stored_i(v[15]), .rx_no_buffer_i(v[14]), .rx_length_i(v[13:3]),
    .rx_partial_byte_i(v[2]), .rx_crc_bad_i(v[1]), .rx_symbol_err_i(v[0]),
    .rx_enable_o(ren), .half_duplex_o(hdx));
  mfs_eng_model eng_u (.clk_i(clk), .req_i(rq), .vec_i(vw), .done_o(dn),
    .vec_o(v));
  function automatic [23:0] top(input integer n);
    top = (n == 0 || n == 3) ? 24'hFFFFFF
      : (n inside {1, 2, 6, 11}) ? 24'h00FFFF : 24'h0000FF;
  endfunction
  function automatic [11:0] bump(input [25:0] x, input [1:0] d,
    input [31:0] c);
    logic ok, vl, e;
    logic [4:0] k;
    ok = !x[25];
    k = x[24:20];
    vl = x[13:3] >= 64 && x[13:3] <= (c[8] ? 1536 : 1518);
    e = x[1] | x[0];
    bump = d[0] ? {1'b0,
      ok && x[17] && c[9] && k == 0,
      x[25], ok && k == 16,
      ok && x[19], ok && x[18] && k == 0, 3'h0,
      ok && k > 1 && k < 16, ok && k == 1,
      ok && k < 16} : 12'h0;
    if (d[1] && c[3])
      bump = bump | {x[16] && x[14], 5'h0,
        vl && x[2] && e, vl && !x[2] && e,
        x[16] && x[15] && vl && !x[2] && !e, 3'h0};
  endfunction
  always @(posedge clk)
  begin
    inc = bump(v, dn, ctl);
    if (cyc && stb && !ack && !we)
      rdexp = adr > 8'h30 ? 0 : adr == 0 ? ctl : cnt[adr[7:2] - 1];
    for (int n = 0; n < 12; n++)
    begin
      if (cyc && stb && !ack && adr == 4 * n + 4)
        cnt[n] = we ? (ctl[7] && sel == 4'hF ? dat[23:0] : cnt[n]) : 0;
      cnt[n] = cnt[n] & top(n);
      cnt[n] = cnt[n] + (inc[n] && cnt[n] != top(n));
      if (rst)
        cnt[n] = 0;
    end
    if (cyc && stb && !ack && we && adr == 0)
      ctl = dat & `MFS_CTRL_MASK;
    if (rst)
      ctl = 0;
  end
  task automatic chk(input [31:0] g, e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    integer n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    do @(posedge clk); while (!ack && ++n < 50);
    {cyc, stb} <= 2'b00;
    if (n == 50)
      miscompares++;
    if (!w)
      chk(dato, rdexp);
  endtask
  task automatic frame;
    logic [31:0] r;
    integer m;
    r = $random(seed);
    m = r[3] ? lens[r[6:4] % 6] : 60 + r[31:21] % 1490;
    @(posedge clk);
    rq <= {r[7] | !r[8], r[8]};
    vw <= {r[9:8] == 2'h3, 5'(r[24:20] % 17), r[12:10], r[13], r[14],
      r[14] ? 1'b0 : r[15], 11'(m), r[18:16]};
    @(posedge clk);
    rq <= 2'b00;
  endtask
  task stop_test;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 0;
    for (p = 0; p < 4; p++)
    begin
      bus(1, 8'h00, ctls[p], 4'hF);
      @(negedge clk);
      chk({30'h0, ren, hdx}, {30'h0, ctls[p][3], ctls[p][9]});
      for (i = 1; i < 14; i++)
        bus(1, 8'(4 * i), 32'hFFFFFFFF, i == 5 ? 4'h7 : 4'hF);
      repeat (60)
        fork
          frame();
          begin
            repeat ($unsigned($random(seed)) % 3) @(posedge clk);
            bus(0, 8'(4 + 4 * ($unsigned($random(seed)) % 12)), 0, 4'hF);
          end
        join
      if (p == 1)
      begin
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
      end
      for (i = 0; i < 14; i++)
        bus(0, 8'(4 * i), 0, 4'hF);
      bus(0, 8'hFC, 0, 4'hF);
    end
    stop_test;
  end
  initial
  begin
    #200000;
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
